// file: rtl/crs_core_regs.sv
// programmer-visible register set of the 8-bit core
module crs_core_regs
    import crs_pkg::*;
#(
    parameter int NUM_IRQ = CRS_NUM_IRQ
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input crs_exec_s exec,
    input wire logic pc_load,
    input wire logic [15:0] pc_value,
    input wire logic pc_step,
    input wire logic irq_enter,
    input wire logic [15:0] irq_vector,
    input wire logic trap,
    input wire logic [NUM_IRQ-1:0] irq_req,
    output crs_regs_s regs,
    output logic [15:0] program_counter,
    output logic [7:0] push_data,
    output logic push_valid,
    output logic irq_take,
    output logic [$clog2(NUM_IRQ)-1:0] irq_id,
    output logic [NUM_IRQ-1:0] irq_pending,
    output logic flag_test
);
    // ------------------------------------------------------------
    // reset synchroniser
    // ------------------------------------------------------------
    logic [1:0] rst_sync;
    logic rst_n;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        crs_regs_s r;
        logic [2:0] push_cnt;
        logic push_act;
        logic [7:0] push_byte;
        // the vector overwrites the counter at entry, so its high byte is kept here
        logic [7:0] pc_high_save;
    } crs_state_s;

    crs_state_s st_reg;
    crs_state_s st_next;
    logic [7:0] flags;
    logic [15:0] pc_cur;
    logic [15:0] pc_new;
    logic mask_now;
    logic ack;

    assign flags = st_reg.r.condition_flags;
    assign pc_cur = {st_reg.r.program_counter_high, st_reg.r.program_counter_low};
    assign mask_now = flags[CRS_FLAG_I];
    // an entry refused during a push must not consume a pending request
    assign ack = irq_enter && !trap && !st_reg.push_act;

    crs_pending #(
        .NUM_IRQ(NUM_IRQ)
    ) u_pending (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .irq_req(irq_req),
        .irq_ack(ack),
        .mask(mask_now),
        .irq_take(irq_take),
        .irq_id(irq_id),
        .pending(irq_pending)
    );

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        pc_new = pc_cur;
        if (pc_step) begin
            pc_new = pc_cur + 16'h0001;
        end
        if (pc_load) begin
            pc_new = pc_value;
        end
        if (exec.valid) begin
            // only the flags named per op are written below
            unique case (exec.op)
                CRS_OP_ADD, CRS_OP_ADC: begin
                    st_next.r.condition_flags[CRS_FLAG_H] =
                        exec.result[4] ^ exec.operand[4] ^ exec.data[4];
                    st_next.r.condition_flags[CRS_FLAG_C] = exec.carry_out;
                end
                CRS_OP_SUB: begin
                    st_next.r.condition_flags[CRS_FLAG_C] = exec.carry_out;
                end
                CRS_OP_SHIFT, CRS_OP_BTJ: begin
                    st_next.r.condition_flags[CRS_FLAG_C] = exec.carry_out;
                end
                CRS_OP_SET_CARRY: begin
                    st_next.r.condition_flags[CRS_FLAG_C] = 1'b1;
                end
                CRS_OP_RESET_CARRY: begin
                    st_next.r.condition_flags[CRS_FLAG_C] = 1'b0;
                end
                CRS_OP_SET_MASK: begin
                    st_next.r.condition_flags[CRS_FLAG_I] = 1'b1;
                end
                CRS_OP_CLEAR_MASK: begin
                    st_next.r.condition_flags[CRS_FLAG_I] = 1'b0;
                end
                CRS_OP_INTERRUPT_RETURN_INSTR: begin
                    // restores flags from the stack and ends unmasked unless an entry is taken in the same cycle
                    st_next.r.condition_flags =
                        (exec.data | CRS_FLAGS_FIXED) & ~(8'h01 << CRS_FLAG_I);
                end
                CRS_OP_POP_FLAGS, CRS_OP_WRITE_FLAGS: begin
                    st_next.r.condition_flags = exec.data | CRS_FLAGS_FIXED;
                end
                default: begin
                end
            endcase
            if (exec.op inside {CRS_OP_ADD, CRS_OP_ADC, CRS_OP_SUB, CRS_OP_LOGIC,
                                CRS_OP_SHIFT}) begin
                st_next.r.condition_flags[CRS_FLAG_N] = exec.result[7];
                st_next.r.condition_flags[CRS_FLAG_Z] = (exec.result == 8'h00);
            end
            // registers written only through this instruction path
            unique case (exec.dst)
                CRS_DST_ACC: st_next.r.acc = exec.result;
                CRS_DST_IDX: begin
                    if (exec.idx_second) begin
                        st_next.r.idx_second = exec.result;
                    end else begin
                        st_next.r.idx_first = exec.result;
                    end
                end
                default: begin
                end
            endcase
            if (exec.op == CRS_OP_INTERRUPT_RETURN_INSTR) begin
                // second index is not part of the restored context
                st_next.r.idx_second = st_reg.r.idx_second;
            end
        end
        // context save: low counter, high counter, index, accumulator, flags
        if (st_reg.push_act) begin
            unique case (st_reg.push_cnt)
                3'h0: st_next.push_byte = st_reg.pc_high_save;
                3'h1: st_next.push_byte = st_reg.r.idx_first;
                3'h2: st_next.push_byte = st_reg.r.acc;
                3'h3: st_next.push_byte = st_reg.r.condition_flags;
                default: st_next.push_byte = 8'h00;
            endcase
            st_next.push_cnt = st_reg.push_cnt + 3'h1;
            st_next.push_act = (st_reg.push_cnt != 3'h4);
        end
        if (irq_enter && !st_reg.push_act) begin
            // snapshot taken in the same cycle the vector replaces the counter; its bytes are pushed afterwards
            st_next.push_act = 1'b1;
            st_next.push_cnt = 3'h0;
            st_next.push_byte = st_reg.r.program_counter_low;
            st_next.pc_high_save = st_reg.r.program_counter_high;
            st_next.r.condition_flags[CRS_FLAG_I] = 1'b1;
            pc_new = irq_vector;
        end
        st_next.r.program_counter_low = pc_new[7:0];
        st_next.r.program_counter_high = pc_new[15:8];
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_reg.r.acc <= CRS_ACC_RST;
            st_reg.r.idx_first <= CRS_IDX_RST;
            st_reg.r.idx_second <= CRS_IDX_RST;
            st_reg.r.program_counter_low <= CRS_PC_RST[7:0];
            st_reg.r.program_counter_high <= CRS_PC_RST[15:8];
            st_reg.r.condition_flags <= CRS_FLAGS_RST;
            st_reg.push_cnt <= 3'h0;
            st_reg.push_act <= 1'b0;
            st_reg.push_byte <= 8'h00;
            st_reg.pc_high_save <= 8'h00;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign regs = st_reg.r;
    assign program_counter = pc_cur;
    assign push_data = st_reg.push_byte;
    assign push_valid = st_reg.push_act;
    // bit test of any single flag, selected by the low operand bits
    assign flag_test = flags[exec.operand[2:0]];
endmodule // crs_core_regs

// file: rtl/crs_pkg.sv
// package: register-set constants, operation codes and carrier structs
package crs_pkg;
    localparam int CRS_DATA_W = 8;
    localparam int CRS_ADDR_W = 16;
    // flag bit positions inside condition_flags
    localparam int CRS_FLAG_C = 0;
    localparam int CRS_FLAG_Z = 1;
    localparam int CRS_FLAG_N = 2;
    localparam int CRS_FLAG_I = 3;
    localparam int CRS_FLAG_H = 4;
    // reset values; unknown flag bits are defined as one here
    localparam logic [7:0] CRS_FLAGS_RST = 8'hE8;
    localparam logic [7:0] CRS_FLAGS_FIXED = 8'hE0;
    localparam logic [7:0] CRS_ACC_RST = 8'h00;
    localparam logic [7:0] CRS_IDX_RST = 8'h00;
    localparam logic [15:0] CRS_PC_RST = 16'h0000;
    localparam int CRS_NUM_IRQ = 8;

    typedef enum logic [3:0] {
        CRS_OP_NONE = 4'h0,
        CRS_OP_ADD = 4'h1,
        CRS_OP_ADC = 4'h2,
        CRS_OP_SUB = 4'h3,
        CRS_OP_LOGIC = 4'h4,
        CRS_OP_SHIFT = 4'h5,
        CRS_OP_BTJ = 4'h6,
        CRS_OP_SET_CARRY = 4'h7,
        CRS_OP_RESET_CARRY = 4'h8,
        CRS_OP_SET_MASK = 4'h9,
        CRS_OP_CLEAR_MASK = 4'hA,
        CRS_OP_INTERRUPT_RETURN_INSTR = 4'hB,
        CRS_OP_POP_FLAGS = 4'hC,
        CRS_OP_WRITE_FLAGS = 4'hD
    } crs_op_e;

    typedef enum logic [1:0] {
        CRS_DST_NONE = 2'h0,
        CRS_DST_ACC = 2'h1,
        CRS_DST_IDX = 2'h2
    } crs_dst_e;

    // one executed instruction as presented by the sequencer
    typedef struct packed {
        logic valid;
        crs_op_e op;
        crs_dst_e dst;
        logic idx_second;
        logic [7:0] operand;
        logic [7:0] result;
        logic carry_out;
        logic [7:0] data;
    } crs_exec_s;

    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] idx_first;
        logic [7:0] idx_second;
        logic [7:0] program_counter_low;
        logic [7:0] program_counter_high;
        logic [7:0] condition_flags;
    } crs_regs_s;
endpackage

// file: rtl/crs_pending.sv
// pending interrupt latch with priority pick
module crs_pending
    import crs_pkg::*;
#(
    parameter int NUM_IRQ = CRS_NUM_IRQ
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [NUM_IRQ-1:0] irq_req,
    input wire logic irq_ack,
    input wire logic mask,
    output logic irq_take,
    output logic [$clog2(NUM_IRQ)-1:0] irq_id,
    output logic [NUM_IRQ-1:0] pending
);
    typedef struct packed {
        logic [NUM_IRQ-1:0] pend;
    } crs_pend_s;

    crs_pend_s st_reg;
    crs_pend_s st_next;
    logic [NUM_IRQ-1:0] ack_vec;

    // lowest index wins; a new request in the acknowledge cycle survives
    always_comb begin
        irq_id = '0;
        ack_vec = '0;
        for (int i = NUM_IRQ - 1; i >= 0; i--) begin
            if (st_reg.pend[i]) begin
                irq_id = i[$clog2(NUM_IRQ)-1:0];
            end
        end
        if (irq_ack) begin
            ack_vec[irq_id] = 1'b1;
        end
        st_next.pend = (st_reg.pend & ~ack_vec) | irq_req;
    end

    assign irq_take = |st_reg.pend && !mask;
    assign pending = st_reg.pend;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule // crs_pending

// file: tb/crs_core_regs_monitor.sv
// assertion checker for the core register set
module crs_core_regs_monitor
    import crs_pkg::*;
#(
    parameter int NUM_IRQ = CRS_NUM_IRQ
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire crs_exec_s exec,
    input wire logic pc_load,
    input wire logic pc_step,
    input wire logic irq_enter,
    input wire logic [15:0] irq_vector,
    input wire crs_regs_s regs,
    input wire logic [15:0] program_counter,
    input wire logic push_valid,
    input wire logic irq_take,
    input wire logic [NUM_IRQ-1:0] irq_pending
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    logic [7:0] f;
    logic ok;
    logic hc;
    assign f = regs.condition_flags;
    // entry overrides only the mask flag and counter written by an instruction in the same cycle
    assign ok = exec.valid && !irq_enter && !push_valid;
    assign hc = exec.result[4] ^ exec.operand[4] ^ exec.data[4];
    pc_pair_a: assert property (
        program_counter == {regs.program_counter_high, regs.program_counter_low})
        else $error("counter bytes disagree");
    pc_step_a: assert property (
        pc_step && !pc_load && !irq_enter |=> program_counter == $past(program_counter) + 16'h0001)
        else $error("counter did not step");
    half_carry_a: assert property (
        ok && exec.op inside {CRS_OP_ADD, CRS_OP_ADC} |=> f[CRS_FLAG_H] == $past(hc))
        else $error("half carry wrong");
    neg_zero_a: assert property (
        ok && exec.op inside {CRS_OP_ADD, CRS_OP_ADC, CRS_OP_SUB, CRS_OP_LOGIC} |=>
        f[CRS_FLAG_N] == $past(exec.result[7]) && f[CRS_FLAG_Z] == ($past(exec.result) == 8'h00))
        else $error("sign or zero flag wrong");
    carry_out_a: assert property (
        ok && exec.op inside {CRS_OP_ADD, CRS_OP_ADC, CRS_OP_SUB, CRS_OP_SHIFT, CRS_OP_BTJ}
        |=> f[CRS_FLAG_C] == $past(exec.carry_out))
        else $error("carry flag wrong");
    carry_force_a: assert property (
        (ok && exec.op == CRS_OP_SET_CARRY |=> f[CRS_FLAG_C]) and
        (ok && exec.op == CRS_OP_RESET_CARRY |=> !f[CRS_FLAG_C]))
        else $error("carry force wrong");
    entry_mask_a: assert property (
        irq_enter && !push_valid |=> f[CRS_FLAG_I] && program_counter == $past(irq_vector))
        else $error("entry did not mask or vector");
    push_run_a: assert property (
        $rose(push_valid) |-> push_valid [*5] ##1 !push_valid)
        else $error("push run length wrong");
    idx_keep_a: assert property (
        push_valid |-> $stable(regs.idx_second))
        else $error("second index moved on entry");
    take_gate_a: assert property (
        irq_take == ((|irq_pending) && !f[CRS_FLAG_I]))
        else $error("take disagrees with pending and mask");
    pend_hold_a: assert property (
        !irq_enter |=> (irq_pending & $past(irq_pending)) == $past(irq_pending))
        else $error("pending request dropped");
    flags_hold_a: assert property (
        (!exec.valid || exec.op == CRS_OP_NONE) && !irq_enter |=> $stable(f))
        else $error("flags moved without cause");
    mask_soft_a: assert property (
        $fell(f[CRS_FLAG_I]) |-> $past(exec.valid))
        else $error("mask cleared without instruction");
endmodule // crs_core_regs_monitor

bind crs_core_regs crs_core_regs_monitor #(.NUM_IRQ(NUM_IRQ)) u_mon (.clk_sys(clk_sys),
    .rstn(rstn), .exec(exec), .pc_load(pc_load), .pc_step(pc_step), .irq_enter(irq_enter),
    .irq_vector(irq_vector), .regs(regs),
    .program_counter(program_counter), .push_valid(push_valid), .irq_take(irq_take),
    .irq_pending(irq_pending));

// file: tb/test_crs_core_regs.sv
// self-checking bench for the core register set
module test_crs_core_regs import crs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'h0;
    logic rstn = 1'h0;
    crs_exec_s exec = '0;
    logic pc_load = 1'h0, pc_step = 1'h0, irq_enter = 1'h0, trap = 1'h0;
    logic [15:0] pc_value = 16'h0000, irq_vector = 16'h0000, program_counter;
    logic [7:0] irq_req = 8'h00, irq_pending, push_data;
    logic [7:0] pb [5] = '{8'hCD, 8'hAB, 8'h7F, 8'h10, 8'hFD};
    crs_regs_s regs;
    logic push_valid, irq_take, flag_test;
    logic [2:0] irq_id;
    int n_mismatch = 0;
    int n_compared = 0;
    always #5 clk_sys = ~clk_sys;
    crs_core_regs #(.NUM_IRQ(8)) uut (.clk_sys(clk_sys), .rstn(rstn), .exec(exec),
        .pc_load(pc_load), .pc_value(pc_value), .pc_step(pc_step), .irq_enter(irq_enter),
        .irq_vector(irq_vector), .trap(trap), .irq_req(irq_req), .regs(regs),
        .program_counter(program_counter), .push_data(push_data), .push_valid(push_valid),
        .irq_take(irq_take), .irq_id(irq_id), .irq_pending(irq_pending), .flag_test(flag_test));
    // ----
    // tasks
    // ----
    task automatic wrap_up();
        $display("mismatches %0d, compared %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // valid drops for a full cycle so no field is assigned twice in one step
    task automatic run(input crs_op_e op, input crs_dst_e dst, input logic sec,
        input logic [7:0] opd, input logic [7:0] dat, input logic [7:0] res, input logic co);
        exec = '{1'h1, op, dst, sec, opd, res, co, dat};
        @(negedge clk_sys);
        exec.valid = 1'h0;
        @(negedge clk_sys);
    endtask
    task automatic t_reset();
        chk("flags", 16'h00E8, regs.condition_flags);
        chk("acc", 16'h0000, {regs.acc, regs.idx_first});
        chk("pc", 16'h0000, program_counter);
        chk("push", 16'h0000, push_valid);
    endtask
    task automatic t_arith();
        run(CRS_OP_ADD, CRS_DST_ACC, 1'h0, 8'h0F, 8'h01, 8'h10, 1'h0);
        chk("acc", 16'h0010, regs.acc);
        chk("flags", 16'h00F8, regs.condition_flags);
        run(CRS_OP_ADC, CRS_DST_NONE, 1'h0, 8'h80, 8'h80, 8'h00, 1'h1);
        chk("flags", 16'h00EB, regs.condition_flags);
        run(CRS_OP_SUB, CRS_DST_IDX, 1'h1, 8'h10, 8'h00, 8'h80, 1'h1);
        chk("idx2", 16'h0080, regs.idx_second);
        chk("flags", 16'h00ED, regs.condition_flags);
        run(CRS_OP_LOGIC, CRS_DST_IDX, 1'h0, 8'h00, 8'h00, 8'h7F, 1'h0);
        chk("idx1", 16'h7F10, {regs.idx_first, regs.acc});
        chk("flags", 16'h00E9, regs.condition_flags);
        run(CRS_OP_RESET_CARRY, CRS_DST_NONE, 1'h0, 8'h00, 8'h00, 8'h00, 1'h0);
        chk("flags", 16'h00E8, regs.condition_flags);
        run(CRS_OP_SET_CARRY, CRS_DST_NONE, 1'h0, 8'h00, 8'h00, 8'h00, 1'h0);
        chk("flags", 16'h00E9, regs.condition_flags);
        run(CRS_OP_SHIFT, CRS_DST_NONE, 1'h0, 8'h00, 8'h00, 8'h01, 1'h0);
        chk("carry", 16'h0000, regs.condition_flags[0]);
        run(CRS_OP_BTJ, CRS_DST_NONE, 1'h0, 8'h00, 8'h00, 8'h01, 1'h1);
        chk("carry", 16'h0001, regs.condition_flags[0]);
    endtask
    task automatic t_flags();
        run(CRS_OP_WRITE_FLAGS, CRS_DST_NONE, 1'h0, 8'h00, 8'h15, 8'h00, 1'h0);
        chk("flags", 16'h00F5, regs.condition_flags);
        exec.operand = 8'h02;
        #1 chk("test", 16'h0001, flag_test);
        exec.operand = 8'h03;
        #1 chk("test", 16'h0000, flag_test);
        @(negedge clk_sys);
        run(CRS_OP_SET_MASK, CRS_DST_NONE, 1'h0, 8'h00, 8'h00, 8'h00, 1'h0);
        chk("flags", 16'h00FD, regs.condition_flags);
    endtask
    task automatic t_irq();
        pc_value = 16'hABCD;
        pc_load = 1'h1;
        irq_req = 8'h04;
        @(negedge clk_sys);
        pc_load = 1'h0;
        irq_req = 8'h00;
        @(negedge clk_sys);
        chk("pc", 16'hABCD, program_counter);
        chk("pend", {1'h0, 8'h04}, {irq_take, irq_pending});
        run(CRS_OP_CLEAR_MASK, CRS_DST_NONE, 1'h0, 8'h00, 8'h00, 8'h00, 1'h0);
        chk("take", 16'h0204, {irq_take, 5'h00, irq_id, regs.condition_flags[3]});
        irq_enter = 1'h1;
        irq_vector = 16'h1234;
        // the pushed flag byte may carry either mask value, so that bit is forced to one before the compare
        for (int i = 0; i < 5; i++) begin
            @(negedge clk_sys);
            irq_enter = 1'h0;
            chk("push", {1'h1, pb[i]}, {push_valid, push_data | ((i == 4) ? 8'h08 : 8'h00)});
        end
        chk("pc", 16'h1234, program_counter);
        chk("flags", 16'h00FD, regs.condition_flags);
        chk("pend", 16'h0080, {irq_pending, regs.idx_second});
        @(negedge clk_sys);
        chk("push", 16'h0000, push_valid);
        run(CRS_OP_INTERRUPT_RETURN_INSTR, CRS_DST_NONE, 1'h0, 8'h00, 8'h0B, 8'h00, 1'h0);
        chk("flags", 16'h00E3, regs.condition_flags);
        pc_step = 1'h1;
        @(negedge clk_sys);
        pc_step = 1'h0;
        chk("pc", 16'h1235, program_counter);
        // trap entry keeps the pending request; a second entry during the push is refused
        irq_req = 8'h01;
        trap = 1'h1;
        irq_enter = 1'h1;
        irq_vector = 16'h5678;
        @(negedge clk_sys);
        irq_req = 8'h00;
        trap = 1'h0;
        irq_vector = 16'h9ABC;
        @(negedge clk_sys);
        irq_enter = 1'h0;
        repeat (6) @(negedge clk_sys);
        chk("trap", 16'h5601, {program_counter[15:8], irq_pending});
        chk("trap mask", 16'h0001, regs.condition_flags[3]);
    endtask
    // ----
    // main sequence and hang guard
    // ----
    initial begin
        repeat (4) @(negedge clk_sys);
        rstn = 1'h1;
        repeat (3) @(negedge clk_sys);
        t_reset();
        t_arith();
        t_flags();
        t_irq();
        wrap_up();
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        n_mismatch++;
        wrap_up();
    end
endmodule // test_crs_core_regs
